// ---- design/fpl_params.svh ----
// timing constants and field values shared by both ends of the fast parallel loader
`ifndef FPL_PARAMS_SVH
`define FPL_PARAMS_SVH

// ==========================================================================
// clock
`define FPL_CORE_PERIOD_NS 40
// ==========================================================================
// device side timing, times as printed, counts derived from the core period
`define FPL_CF2ST_NS 600
`define FPL_CF2ST_CYC (`FPL_CF2ST_NS / `FPL_CORE_PERIOD_NS)
`define FPL_STATUS_MIN_US 268
`define FPL_STATUS_MIN_CYC ((`FPL_STATUS_MIN_US * 1000 + `FPL_CORE_PERIOD_NS - 1) / `FPL_CORE_PERIOD_NS)
`define FPL_STATUS_MAX_US 1506
`define FPL_STATUS_MAX_CYC ((`FPL_STATUS_MAX_US * 1000) / `FPL_CORE_PERIOD_NS)
`define FPL_POR_MS 100
`define FPL_POR_CYC ((`FPL_POR_MS * 1000000 + `FPL_CORE_PERIOD_NS - 1) / `FPL_CORE_PERIOD_NS)
`define FPL_INIT_CYC 8576
`define FPL_CD2UM_MIN_US 175
`define FPL_CD2UM_MAX_US 437
// ==========================================================================
// link clock limits
`define FPL_FMAX_MHZ 125
`define FPL_TCLK_MIN_NS (1000 / `FPL_FMAX_MHZ)
`define FPL_CD2CU_NS (4 * `FPL_TCLK_MIN_NS)
`define FPL_CD2CU_CYC ((`FPL_CD2CU_NS + `FPL_CORE_PERIOD_NS - 1) / `FPL_CORE_PERIOD_NS)
// ==========================================================================
// host side timing
`define FPL_CFG_LOW_US 2
`define FPL_CFG_LOW_CYC ((`FPL_CFG_LOW_US * 1000 + `FPL_CORE_PERIOD_NS - 1) / `FPL_CORE_PERIOD_NS)
`define FPL_ST2CK_US 2
`define FPL_ST2CK_CYC ((`FPL_ST2CK_US * 1000 + `FPL_CORE_PERIOD_NS - 1) / `FPL_CORE_PERIOD_NS)
// ==========================================================================
// widths
`define FPL_DATA_W 16
`define FPL_CNT_W 24
`define FPL_FIFO_DEPTH 8

`endif

// ---- design/fpl_pkg.sv ----
// types and the clock-to-data ratio shared by both ends of the fast parallel loader
package fpl_pkg;

	// ==========================================================================
	// device state
	typedef enum logic [2:0] {
		FPL_D_POR,
		FPL_D_STAT_LOW,
		FPL_D_LOAD,
		FPL_D_INIT_WAIT,
		FPL_D_INIT,
		FPL_D_USER,
		FPL_D_FAULT
	} fpl_dev_state_t;

	typedef struct packed {
		fpl_dev_state_t st;            // control state
		logic [21:0]    tmr;           // shared delay counter
		logic [1:0]     ph;            // edge phase within a word
		logic [23:0]    cnt;           // words handed to the user
		logic           status_oe_n;   // low pulls status low
		logic           load_complete; // completion line
		logic           user_mode;     // device running
		logic           lnk_clr;       // clears the link-side capture
		logic           fault;         // overflow seen
		logic [2:0]     tgl_s;         // toggle synchroniser and history
		logic [1:0]     req_s;         // request synchroniser
		logic [1:0]     stat_s;        // status wire synchroniser
		logic [2:0]     uclk_s;        // user init clock synchroniser
	} fpl_dev_regs_t;

	typedef struct packed {
		logic        tgl;  // flips on every link rising edge
		logic [15:0] data; // word captured on that edge
	} fpl_lnk_regs_t;

	// ==========================================================================
	// host state
	typedef enum logic [2:0] {
		FPL_H_IDLE,
		FPL_H_REQ,
		FPL_H_WSTH,
		FPL_H_GAP,
		FPL_H_LOADW,
		FPL_H_CLK,
		FPL_H_WDONE,
		FPL_H_UDLY
	} fpl_host_state_t;

	typedef struct packed {
		fpl_host_state_t st;
		logic [15:0]     tmr;
		logic [1:0]      rep;      // edges sent for the current word
		logic [1:0]      div;      // link clock divider phase
		logic [23:0]     words;    // words sent
		logic            req_n;
		logic            tclk;
		logic [15:0]     data;
		logic            stat_oe_n;
		logic            uclk;
		logic            uclk_en;
		logic            busy;
		logic            done;
		logic            src_ready;
		logic [1:0]      stat_s;
		logic [1:0]      done_s;
	} fpl_host_regs_t;

	// ratio minus one: byte wide 1 or 2, word wide 1, 2 or 4
	function automatic logic [1:0] fpl_ratio_m1(input logic width16, input logic encrypt,
			input logic compress);
		logic [1:0] v;
		v = 2'h0;
		if (compress) begin
			v = width16 ? 2'h3 : 2'h1;
		end else if (encrypt && width16) begin
			v = 2'h1;
		end
		return v;
	endfunction

endpackage

// ---- design/fpl_if.sv ----
// pins between the configuration host and the loading device
`timescale 1ns/100ps
`default_nettype none

interface fpl_if;
	logic        cfg_req_n;        // host request, low starts a load
	logic        transfer_clock;   // link clock made by the host
	logic [15:0] data;             // parallel data
	logic        dev_status_o;     // device status drive value
	logic        dev_status_oe_n;  // device status enable, low drives
	logic        host_status_o;    // host status drive value
	logic        host_status_oe_n; // host status enable, low drives
	logic        status_n;         // resolved open-drain status wire
	logic        load_complete;    // completion line from the device
	logic        user_init_clock;  // optional init clock from the host

	// open-drain wire: low when either end drives a low, pulled up otherwise
	assign status_n = ~((~dev_status_oe_n & ~dev_status_o) | (~host_status_oe_n & ~host_status_o));

	modport dev (
		input  cfg_req_n, transfer_clock, data, status_n, user_init_clock,
		output dev_status_o, dev_status_oe_n, load_complete
	);
	modport host (
		input  status_n, load_complete,
		output cfg_req_n, transfer_clock, data, host_status_o, host_status_oe_n, user_init_clock
	);
endinterface

`default_nettype wire

// ---- design/fpl_dev.sv ----
// loading device: link capture, word fifo and the configuration sequence
`timescale 1ns/100ps
`default_nettype none
`include "fpl_params.svh"

// ==========================================================================
// word fifo
module fpl_fifo #(
	parameter int W = 16,
	parameter int D = 8
) (
	input  wire logic         core_clk,
	input  wire logic         rst,
	input  wire logic         flush,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];   // storage
	logic [AW-1:0] wp;       // write pointer
	logic [AW-1:0] rp;       // read pointer
	logic [AW:0]   level;    // words held
	logic          wr;
	logic          rd;

	assign in_ready  = (level != (AW+1)'(D));
	assign out_valid = (level != '0);
	assign out_data  = mem[rp];
	assign wr = in_valid & in_ready;
	assign rd = out_valid & out_ready;

	// pointers wrap at the depth, which must be a power of two
	always_ff @(posedge core_clk) begin
		if (rst || flush) begin
			wp    <= '0;
			rp    <= '0;
			level <= '0;
		end else begin
			if (wr) begin
				mem[wp] <= in_data;
				wp      <= wp + 1'b1;
			end
			if (rd) begin
				rp <= rp + 1'b1;
			end
			level <= level + (AW+1)'(wr) - (AW+1)'(rd);
		end
	end
endmodule

module fpl_dev #(
	parameter int POR_CYC        = `FPL_POR_CYC,
	parameter int STATUS_MIN_CYC = `FPL_STATUS_MIN_CYC,
	parameter int INIT_CYC       = `FPL_INIT_CYC
) (
	input  wire logic        core_clk,
	input  wire logic        rst,
	fpl_if.dev               lnk,
	input  wire logic        width16,
	input  wire logic        encrypt,
	input  wire logic        compress,
	input  wire logic        use_user_clock,
	input  wire logic [23:0] word_total,
	output logic [15:0]      cfg_word,
	output logic             cfg_valid,
	input  wire logic        cfg_ready,
	output logic             user_mode,
	output logic             fault
);
	fpl_pkg::fpl_dev_regs_t r;       // core-domain state
	fpl_pkg::fpl_dev_regs_t next_r;  // its next value
	fpl_pkg::fpl_lnk_regs_t l;       // link-domain state
	fpl_pkg::fpl_lnk_regs_t next_l;  // its next value
	logic [1:0]  rm1;                // ratio minus one
	logic        tog_evt;            // a link rising edge reached the core
	logic        push;               // word into the fifo
	logic        in_ready;           // fifo has room
	logic [15:0] push_word;          // word as stored
	logic        pop;                // word taken by the user

	// ==========================================================================
	// link domain: capture on every rising edge of the host clock
	// cleared asynchronously while no load is open; the link clock is still then,
	// so the release never meets an edge
	always_comb begin
		next_l      = l;
		next_l.tgl  = ~l.tgl;
		next_l.data = lnk.data;
	end

	always_ff @(posedge lnk.transfer_clock or posedge r.lnk_clr) begin
		if (r.lnk_clr) begin
			l <= '0;
		end else begin
			l <= next_l;
		end
	end

	// ==========================================================================
	// fifo between the link capture and the user port
	assign push_word = width16 ? l.data : {8'h00, l.data[7:0]};
	assign pop       = cfg_valid & cfg_ready & (r.st == fpl_pkg::FPL_D_LOAD);

	fpl_fifo #(
		.W (`FPL_DATA_W),
		.D (`FPL_FIFO_DEPTH)
	) u_fifo (
		.core_clk  (core_clk),
		.rst       (rst),
		.flush     (r.st == fpl_pkg::FPL_D_STAT_LOW),
		.in_valid  (push),
		.in_ready  (in_ready),
		.in_data   (push_word),
		.out_valid (cfg_valid),
		.out_ready (cfg_ready & (r.st == fpl_pkg::FPL_D_LOAD)),
		.out_data  (cfg_word)
	);

	// ==========================================================================
	// core domain sequence
	assign rm1     = fpl_pkg::fpl_ratio_m1(width16, encrypt, compress);
	assign tog_evt = r.tgl_s[1] ^ r.tgl_s[2];

	always_comb begin
		next_r        = r;
		push          = 1'b0;
		// synchronisers: first stage feeds only the second
		next_r.tgl_s  = {r.tgl_s[1:0], l.tgl};
		next_r.req_s  = {r.req_s[0], lnk.cfg_req_n};
		next_r.stat_s = {r.stat_s[0], lnk.status_n};
		next_r.uclk_s = {r.uclk_s[1:0], lnk.user_init_clock};
		unique case (r.st)
			// hold status low through the power-on delay
			fpl_pkg::FPL_D_POR: begin
				next_r.status_oe_n = 1'b0;
				next_r.tmr         = r.tmr + 22'h00_0001;
				if (r.tmr == 22'(POR_CYC - 1)) begin
					next_r.st  = fpl_pkg::FPL_D_STAT_LOW;
					next_r.tmr = '0;
				end
			end
			// status low for the least time, then released once request is high
			fpl_pkg::FPL_D_STAT_LOW: begin
				next_r.status_oe_n = 1'b0;
				next_r.lnk_clr     = 1'b1;
				// a restart loads the timer with one, so count to the full figure
				// or the low pulse comes out one cycle short of the least width
				if (r.tmr != 22'(STATUS_MIN_CYC)) begin
					next_r.tmr = r.tmr + 22'h00_0001;
				end else if (r.req_s[1]) begin
					next_r.status_oe_n = 1'b1;
					next_r.lnk_clr     = 1'b0;
					next_r.ph          = 2'h0;
					next_r.cnt         = '0;
					next_r.st          = fpl_pkg::FPL_D_LOAD;
				end
			end
			// take one word every ratio edges; edges while status is held low are ignored
			fpl_pkg::FPL_D_LOAD: begin
				if (tog_evt && r.stat_s[1]) begin
					next_r.ph = (r.ph == rm1) ? 2'h0 : r.ph + 2'h1;
					if (r.ph == 2'h0) begin
						push = in_ready;
						if (!in_ready) begin
							// the link cannot be stalled: a full fifo is a load error
							next_r.fault       = 1'b1;
							next_r.status_oe_n = 1'b0;
							next_r.st          = fpl_pkg::FPL_D_FAULT;
						end
					end
				end
				if (pop) begin
					next_r.cnt = r.cnt + 24'h00_0001;
				end
				if (r.cnt == word_total && !cfg_valid && r.st == fpl_pkg::FPL_D_LOAD
						&& !(tog_evt && r.ph == 2'h0)) begin
					next_r.load_complete = 1'b1;
					next_r.lnk_clr       = 1'b1;
					next_r.tmr           = '0;
					next_r.st            = fpl_pkg::FPL_D_INIT_WAIT;
				end
			end
			// clock-enable delay before counting init cycles
			fpl_pkg::FPL_D_INIT_WAIT: begin
				next_r.tmr = r.tmr + 22'h00_0001;
				if (r.tmr == 22'(`FPL_CD2CU_CYC - 1)) begin
					next_r.tmr = '0;
					next_r.st  = fpl_pkg::FPL_D_INIT;
				end
			end
			// count init cycles on the core clock or on the user clock's rising edges
			fpl_pkg::FPL_D_INIT: begin
				if (!use_user_clock || (r.uclk_s[1] & ~r.uclk_s[2])) begin
					next_r.tmr = r.tmr + 22'h00_0001;
					if (r.tmr == 22'(INIT_CYC - 1)) begin
						next_r.user_mode = 1'b1;
						next_r.st        = fpl_pkg::FPL_D_USER;
					end
				end
			end
			fpl_pkg::FPL_D_USER: begin
				next_r.user_mode = 1'b1;
			end
			// error: status stays low until the host requests again
			fpl_pkg::FPL_D_FAULT: begin
				next_r.status_oe_n = 1'b0;
			end
			// unused state code: park in the error state with status low
			default: begin
				next_r.status_oe_n = 1'b0;
				next_r.st          = fpl_pkg::FPL_D_FAULT;
			end
		endcase
		// a low request restarts from any state after power-on, except during a status low pulse already under way
		if (r.st != fpl_pkg::FPL_D_POR && !r.req_s[1]
				&& !(r.st == fpl_pkg::FPL_D_STAT_LOW && r.tmr != '0 && r.status_oe_n == 1'b0)) begin
			next_r.st            = fpl_pkg::FPL_D_STAT_LOW;
			next_r.tmr           = 22'h00_0001;
			next_r.status_oe_n   = 1'b0;
			next_r.load_complete = 1'b0;
			next_r.user_mode     = 1'b0;
			next_r.fault         = 1'b0;
			next_r.lnk_clr       = 1'b1;
			push                 = 1'b0;
		end
	end

	// registered state, synchronous reset into the power-on delay
	always_ff @(posedge core_clk) begin
		if (rst) begin
			r             <= '0;
			r.st          <= fpl_pkg::FPL_D_POR;
			r.status_oe_n <= 1'b0;
			r.lnk_clr     <= 1'b1;
			r.req_s       <= 2'h3;
			r.stat_s      <= 2'h3;
		end else begin
			r <= next_r;
		end
	end

	// ==========================================================================
	// outputs
	assign lnk.dev_status_o    = 1'b0;
	assign lnk.dev_status_oe_n = r.status_oe_n;
	assign lnk.load_complete   = r.load_complete;
	assign user_mode           = r.user_mode;
	assign fault               = r.fault;
endmodule

`default_nettype wire

// ---- design/fpl_host.sv ----
// configuration host: request pulse, link clock divider and word sender
`timescale 1ns/100ps
`default_nettype none
`include "fpl_params.svh"

module fpl_host (
	input  wire logic        core_clk,
	input  wire logic        rst,
	fpl_if.host              lnk,
	input  wire logic        start,
	input  wire logic        width16,
	input  wire logic        encrypt,
	input  wire logic        compress,
	input  wire logic        use_user_clock,
	input  wire logic        hold_off,
	input  wire logic [23:0] word_total,
	input  wire logic [15:0] src_word,
	input  wire logic        src_valid,
	output logic             src_ready,
	output logic             busy,
	output logic             done
);
	fpl_pkg::fpl_host_regs_t r;       // state
	fpl_pkg::fpl_host_regs_t next_r;  // next state
	logic [1:0]              rm1;     // ratio minus one

	assign rm1 = fpl_pkg::fpl_ratio_m1(width16, encrypt, compress);

	// ==========================================================================
	// sequence; the link clock is core/4, far below the link maximum
	always_comb begin
		next_r           = r;
		next_r.src_ready = 1'b0;
		next_r.stat_oe_n = ~hold_off;
		next_r.stat_s    = {r.stat_s[0], lnk.status_n};
		next_r.done_s    = {r.done_s[0], lnk.load_complete};
		if (r.uclk_en) begin
			next_r.uclk = ~r.uclk;
		end
		unique case (r.st)
			fpl_pkg::FPL_H_IDLE: begin
				if (start) begin
					next_r.st      = fpl_pkg::FPL_H_REQ;
					next_r.req_n   = 1'b0;
					next_r.tmr     = '0;
					next_r.words   = '0;
					next_r.busy    = 1'b1;
					next_r.done    = 1'b0;
					next_r.uclk_en = 1'b0;
					next_r.uclk    = 1'b0;
				end
			end
			// request low for the least pulse width and until status is seen low
			fpl_pkg::FPL_H_REQ: begin
				if (r.tmr != 16'(`FPL_CFG_LOW_CYC - 1)) begin
					next_r.tmr = r.tmr + 16'h0001;
				end else if (!r.stat_s[1]) begin
					next_r.req_n = 1'b1;
					next_r.st    = fpl_pkg::FPL_H_WSTH;
				end
			end
			fpl_pkg::FPL_H_WSTH: begin
				if (r.stat_s[1]) begin
					next_r.tmr = '0;
					next_r.st  = fpl_pkg::FPL_H_GAP;
				end
			end
			// gap after status rises before the first edge
			fpl_pkg::FPL_H_GAP: begin
				next_r.tmr = r.tmr + 16'h0001;
				if (r.tmr == 16'(`FPL_ST2CK_CYC)) begin
					next_r.st = (word_total == '0) ? fpl_pkg::FPL_H_WDONE : fpl_pkg::FPL_H_LOADW;
				end
			end
			// present a word; the clock waits while the source is empty
			fpl_pkg::FPL_H_LOADW: begin
				if (src_valid) begin
					next_r.data      = src_word;
					next_r.src_ready = 1'b1;
					next_r.rep       = 2'h0;
					next_r.div       = 2'h0;
					next_r.st        = fpl_pkg::FPL_H_CLK;
				end
			end
			// ratio periods per word, each two core cycles low then two high
			fpl_pkg::FPL_H_CLK: begin
				next_r.div = r.div + 2'h1;
				if (r.div == 2'h1) begin
					next_r.tclk = 1'b1;
				end
				if (r.div == 2'h3) begin
					next_r.tclk = 1'b0;
					if (r.rep == rm1) begin
						next_r.words = r.words + 24'h00_0001;
						next_r.st    = (r.words + 24'h00_0001 == word_total)
							? fpl_pkg::FPL_H_WDONE : fpl_pkg::FPL_H_LOADW;
					end else begin
						next_r.rep = r.rep + 2'h1;
					end
				end
			end
			fpl_pkg::FPL_H_WDONE: begin
				if (r.done_s[1]) begin
					next_r.tmr = '0;
					next_r.st  = fpl_pkg::FPL_H_UDLY;
				end
			end
			// keep the init clock off for four periods of the fastest link clock after completion
			fpl_pkg::FPL_H_UDLY: begin
				next_r.tmr = r.tmr + 16'h0001;
				if (r.tmr == 16'(`FPL_CD2CU_CYC)) begin
					next_r.uclk_en = use_user_clock;
					next_r.busy    = 1'b0;
					next_r.done    = 1'b1;
					next_r.st      = fpl_pkg::FPL_H_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			r           <= '0;
			r.st        <= fpl_pkg::FPL_H_IDLE;
			r.req_n     <= 1'b1;
			r.stat_oe_n <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	// ==========================================================================
	// outputs
	assign lnk.cfg_req_n        = r.req_n;
	assign lnk.transfer_clock   = r.tclk;
	assign lnk.data             = r.data;
	assign lnk.host_status_o    = 1'b0;
	assign lnk.host_status_oe_n = r.stat_oe_n;
	assign lnk.user_init_clock  = r.uclk;
	assign src_ready            = r.src_ready;
	assign busy                 = r.busy;
	assign done                 = r.done;
endmodule

`default_nettype wire

// ---- test/fpl_chk.sv ----
// concurrent checks on the loader link between host and device
`timescale 1ns/100ps
`default_nettype none
`include "fpl_params.svh"

module fpl_chk #(
	parameter int POR_CYC        = 20,
	parameter int STATUS_MIN_CYC = 30
) (
	input wire logic        core_clk,
	input wire logic        rst,
	input wire logic        cfg_req_n,
	input wire logic        transfer_clock,
	input wire logic [15:0] data,
	input wire logic        dev_status_oe_n,
	input wire logic        status_n,
	input wire logic        load_complete,
	input wire logic        user_init_clock
);
	// ==========================================================================
	// bounds and helper counters
	localparam int CF2ST = `FPL_CF2ST_CYC; // request fall to response, cycles
	localparam int ST2CK = `FPL_ST2CK_CYC; // status high to first clock edge
	logic [31:0] low_cnt; // cycles the device has pulled status
	logic [31:0] hi_cnt;  // cycles pulled while request is high
	logic [31:0] st_hi;   // cycles the status wire has been high

	// counters restart on every change so one long load cannot mask a short one
	always_ff @(posedge core_clk) begin
		if (rst) begin
			low_cnt <= 32'h0000_0000;
			hi_cnt  <= 32'h0000_0000;
			st_hi   <= 32'h0000_0000;
		end else begin
			low_cnt <= dev_status_oe_n ? 32'h0000_0000 : low_cnt + 32'h0000_0001;
			hi_cnt  <= (dev_status_oe_n || !cfg_req_n) ? 32'h0000_0000 : hi_cnt + 32'h0000_0001;
			st_hi   <= status_n ? st_hi + 32'h0000_0001 : 32'h0000_0000;
		end
	end

	// ==========================================================================
	// assertions
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	// a new load starts with the request falling
	sequence s_req_fall;
		$fell(cfg_req_n);
	endsequence

	a_done_drop: assert property (s_req_fall |-> ##[0:CF2ST] !load_complete)
		else $error("completion not dropped after request");
	a_stat_pull: assert property (s_req_fall |-> ##[0:CF2ST] !dev_status_oe_n)
		else $error("status not pulled after request");
	a_stat_min: assert property ($rose(dev_status_oe_n) |-> low_cnt >= STATUS_MIN_CYC)
		else $error("status low pulse too short");
	a_stat_release: assert property (hi_cnt <= POR_CYC + STATUS_MIN_CYC + 4)
		else $error("status not released after request high");
	a_clk_wait: assert property ($rose(transfer_clock) |-> st_hi >= ST2CK)
		else $error("link clock too soon after status");
	a_clk_phase: assert property ($changed(transfer_clock) |=> $stable(transfer_clock))
		else $error("link clock phase too short");
	a_data_setup: assert property ($rose(transfer_clock) |-> $stable(data))
		else $error("data moved at link rising edge");
	a_done_lines: assert property ($rose(load_complete) |-> status_n && cfg_req_n)
		else $error("completion with request or status low");
	a_uclk_gap: assert property ($rose(user_init_clock) |-> load_complete && $past(load_complete))
		else $error("init clock before completion settled");
	a_power_low: assert property ($fell(rst) |-> !dev_status_oe_n [*8])
		else $error("status not low after power up");
endmodule

`default_nettype wire

// ---- test/testbench.sv ----
// self-checking bench: host and device joined over the loader link
`timescale 1ns/100ps
`default_nettype none

module testbench;
	// ==========================================================================
	// settings and signals
	localparam int POR  = 20; // shortened power-on delay
	localparam int SMIN = 30; // shortened status low time
	localparam int INIT = 40; // shortened init count
	localparam int N    = 6;  // words per load, fits the fifo when stalled
	logic        core_clk       = 1'b0;
	logic        rst            = 1'b1;
	logic        start          = 1'b0;
	logic        width16        = 1'b0;
	logic        encrypt        = 1'b0;
	logic        compress       = 1'b0;
	logic        use_user_clock = 1'b0;
	logic        hold_off       = 1'b0;
	logic        cfg_ready      = 1'b0;
	logic        slow           = 1'b0; // stall both user sides
	logic [23:0] word_total     = 24'h00_0006;
	logic [15:0] src_word;
	logic        src_valid;
	logic        src_ready, busy, done, cfg_valid, user_mode, fault;
	logic [15:0] cfg_word;
	int          sent, rcvd, edges, ld, cyc, bad_count, compares;

	always #20 core_clk = ~core_clk;

	fpl_if lnk ();
	fpl_host u_fpl_host (.core_clk, .rst, .lnk(lnk.host), .start, .width16, .encrypt,
		.compress, .use_user_clock, .hold_off, .word_total, .src_word, .src_valid,
		.src_ready, .busy, .done);
	fpl_dev #(.POR_CYC(POR), .STATUS_MIN_CYC(SMIN), .INIT_CYC(INIT)) u_fpl_dev (.core_clk,
		.rst, .lnk(lnk.dev), .width16, .encrypt, .compress, .use_user_clock, .word_total,
		.cfg_word, .cfg_valid, .cfg_ready, .user_mode, .fault);
	fpl_chk #(.POR_CYC(POR), .STATUS_MIN_CYC(SMIN)) u_fpl_chk (.core_clk, .rst,
		.cfg_req_n(lnk.cfg_req_n), .transfer_clock(lnk.transfer_clock), .data(lnk.data),
		.dev_status_oe_n(lnk.dev_status_oe_n), .status_n(lnk.status_n),
		.load_complete(lnk.load_complete), .user_init_clock(lnk.user_init_clock));

	// ==========================================================================
	// helpers
	// each load gets its own pattern in the upper byte, so a stale word shows in word wide loads
	function automatic logic [15:0] word_of(input int l, input int i);
		return 16'h5a3c ^ {l[3:0], 4'h0, i[7:0]};
	endfunction

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic end_sim;
		if (bad_count == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	function automatic logic cond(input int k);
		case (k)
			0: return lnk.load_complete;
			1: return user_mode;
			default: return done;
		endcase
	endfunction

	// bounded wait, counts the cycles it took
	task automatic waitfor(input int k, output int n);
		n = 0;
		while (cond(k) !== 1'b1) begin
			@(negedge core_clk);
			n++;
			if (n > 5000) begin
				bad_count++;
				$display("wrong value wait %0d expected 1 seen 0", k);
				end_sim();
			end
		end
	endtask

	// ==========================================================================
	// user sides: source advances on each taken word, sink stalls when slow
	assign src_word  = word_of(ld, sent);
	assign src_valid = (sent < N) && !(slow && cyc[2]);
	always @(negedge core_clk) begin
		cyc++;
		if (src_ready === 1'b1)
			sent++;
		cfg_ready <= slow ? cyc[1] : 1'b1;
	end
	always @(posedge core_clk) begin
		if (!rst && cfg_valid === 1'b1 && cfg_ready) begin
			chk("word", width16 ? word_of(ld, rcvd) : {8'h00, word_of(ld, rcvd) >> 0} & 32'h0000_00ff, cfg_word);
			rcvd++;
		end
	end
	always @(posedge lnk.transfer_clock) edges++;

	// one whole load in the given mode
	task automatic load(input logic [2:0] m, input logic hs, input logic uc);
		int r;
		int n;
		{width16, encrypt, compress} = m;
		use_user_clock = uc;
		hold_off = hs;
		slow = m[0];
		r = compress ? (width16 ? 4 : 2) : ((width16 && encrypt) ? 2 : 1);
		sent = 0;
		rcvd = 0;
		edges = 0;
		ld++;
		start = 1'b1;
		@(negedge core_clk);
		start = 1'b0;
		// completion and user mode of the last load stand until the restart clears them
		repeat (8) @(negedge core_clk);
		chk("restart lines", 0, {lnk.load_complete, user_mode});
		if (hs) begin
			// host holds status low, nothing may move meanwhile
			repeat (300) @(negedge core_clk);
			chk("held status", 0, lnk.status_n);
			chk("held edges", 0, edges);
			hold_off = 1'b0;
		end
		waitfor(0, n);
		chk("words at completion", N, rcvd);
		waitfor(1, n);
		if (uc)
			chk("user clock init", 1, n >= 2 * INIT && n <= 2 * INIT + 20);
		else
			chk("init time", 1, n >= INIT && n <= INIT + 6);
		waitfor(2, n);
		chk("edges", N * r, edges);
		chk("lines", 32'h0000_001e, {busy, lnk.cfg_req_n, lnk.status_n, lnk.load_complete,
			user_mode, fault});
	endtask

	// ==========================================================================
	// main sequence
	initial begin
		repeat (20) @(negedge core_clk);
		rst = 1'b0;
		repeat (2) @(negedge core_clk);
		chk("power status", 0, lnk.status_n);
		load(3'h0, 1'b1, 1'b0);
		for (int m = 0; m < 8; m++) load(m[2:0], 1'b0, m == 7);
		end_sim();
	end
endmodule

`default_nettype wire
